// ==== verilog/nt_maint_msg.sv ====
// Network-side layer 1 maintenance message sender and receiver
`timescale 1ns/1ps
`include "nt_maint_defs.svh"

module nt_maint_msg import nt_maint_pkg::*; #(
	parameter int         MF_CYCLES      = `MF_CYCLES,
	parameter bit         MODEM_ROLE     = 1'b0,
	parameter logic [3:0] LOOP1_IND_CODE = 4'hd,
	parameter logic [3:0] LOOP2_IND_CODE = 4'hb,
	parameter logic [3:0] LOOP12_IND_CODE = 4'h9
) (
	// Clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_arst_n,
	// Upstream characters from the frame logic
	input  wire logic        i_up_strobe,
	input  wire logic [3:0]  i_up_char,
	// Network-side condition pins
	input  wire logic        i_pwr_fail,
	input  wire logic        i_net_sig_lost,
	// Block error events
	input  wire logic        i_blk_err_in,
	input  wire logic        i_blk_err_out,
	// Self test
	input  wire logic        i_selftest_running,
	input  wire logic        i_selftest_done,
	input  wire logic        i_selftest_pass,
	// Other downstream conditions
	input  wire logic        i_disruptive_op,
	input  wire logic        i_modem_master,
	// Downstream characters to the frame logic
	output logic             o_mf_tick,
	output logic [3:0]       o_sc1_char,
	output logic [15:0]      o_rsvd_sc_chars,
	// Requests accepted from the terminals
	output logic             o_loop_first,
	output logic             o_loop_second,
	output logic             o_selftest_req,
	output logic             o_te_power_loss
);

	// ------------------------------------------------------------
	// Reset release and pin synchronisers
	// ------------------------------------------------------------
	logic rst_meta_reg, rst_n;
	logic pwr_meta_reg, pwr_reg;
	logic lost_meta_reg, lost_reg;

	// Reset asserts at once and releases two edges later
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// Pins are asynchronous to the clock
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_meta_reg  <= 1'b0;
			pwr_reg       <= 1'b0;
			lost_meta_reg <= 1'b0;
			lost_reg      <= 1'b0;
		end else begin
			pwr_meta_reg  <= i_pwr_fail;
			pwr_reg       <= pwr_meta_reg;
			lost_meta_reg <= i_net_sig_lost;
			lost_reg      <= lost_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// Multiframe timing and upstream acceptance
	// ------------------------------------------------------------
	logic       tick;
	logic       acc;
	logic [3:0] acc_code;

	nt_mf_timer #(.CYCLES(MF_CYCLES)) u_timer (
		.i_clk   (i_mclk),
		.i_rst_n (rst_n),
		.o_tick  (tick)
	);

	nt_maint_rx u_rx (
		.i_clk      (i_mclk),
		.i_rst_n    (rst_n),
		.i_strobe   (i_up_strobe),
		.i_char     (i_up_char),
		.o_acc      (acc),
		.o_acc_code (acc_code)
	);

	// ------------------------------------------------------------
	// Accepted upstream messages
	// ------------------------------------------------------------
	logic loop1_reg, loop1_next;
	logic loop2_reg, loop2_next;
	logic st_seen_reg, st_seen_next;
	logic st_req_reg, st_req_next;
	logic te_pl_reg, te_pl_next;

	// Loops hold while requested; any other accepted code releases
	always_comb begin
		loop1_next   = loop1_reg;
		loop2_next   = loop2_reg;
		st_seen_next = st_seen_reg;
		te_pl_next   = te_pl_reg;
		st_req_next  = 1'b0;
		if (acc) begin
			loop1_next   = (acc_code == `UP_LOOP1) || (acc_code == `UP_LOOP12);
			loop2_next   = (acc_code == `UP_LOOP2) || (acc_code == `UP_LOOP12);
			st_seen_next = (acc_code == `UP_ST_REQ);
			st_req_next  = (acc_code == `UP_ST_REQ) && !st_seen_reg;
			te_pl_next   = (acc_code == `UP_PWR_LOSS);
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			loop1_reg   <= 1'b0;
			loop2_reg   <= 1'b0;
			st_seen_reg <= 1'b0;
			st_req_reg  <= 1'b0;
			te_pl_reg   <= 1'b0;
		end else begin
			loop1_reg   <= loop1_next;
			loop2_reg   <= loop2_next;
			st_seen_reg <= st_seen_next;
			st_req_reg  <= st_req_next;
			te_pl_reg   <= te_pl_next;
		end
	end

	// ------------------------------------------------------------
	// Downstream message selection
	// ------------------------------------------------------------
	msg_class_t cls_reg, cls_next, cand;
	logic [2:0] rep_reg, rep_next;
	logic       rep_done;
	logic       st_rpt_reg, st_rpt_next;
	logic       st_pass_reg, st_pass_next;
	logic       err_in_reg, err_in_next;
	logic       err_out_reg, err_out_next;
	logic       err_now_reg, err_now_next;
	logic [3:0] char_reg, char_next;
	logic       send_err;

	// Code carried by each class; unassigned codes never appear
	function automatic logic [3:0] class_code(input msg_class_t c, input logic run,
		input logic pass, input logic l1, input logic l2);
		case (c)
			cls_pwr:     class_code = `DN_PWR_LOSS;
			cls_selftst: class_code = run ? `DN_ST_RUN
				: (pass ? `DN_ST_PASS : `DN_ST_FAIL);
			cls_loop:    class_code = (l1 && l2) ? LOOP12_IND_CODE
				: (l1 ? LOOP1_IND_CODE : LOOP2_IND_CODE);
			cls_rx_loss: class_code = `DN_RX_LOSS;
			cls_disrupt: class_code = `DN_DISRUPT;
			cls_modem:   class_code = `DN_MODEM;
			default:     class_code = `DN_IDLE;
		endcase
	endfunction

	// Highest pending class; ordering sets the rank, the boundary update decides pre-emption
	always_comb begin
		if (pwr_reg) begin
			cand = cls_pwr;
		end else if (i_selftest_running || st_rpt_reg) begin
			cand = cls_selftst;
		end else if (loop1_reg || loop2_reg) begin
			cand = cls_loop;
		end else if (lost_reg) begin
			cand = cls_rx_loss;
		end else if (i_disruptive_op) begin
			cand = cls_disrupt;
		end else if (MODEM_ROLE && i_modem_master) begin
			cand = cls_modem;
		end else begin
			cand = cls_idle;
		end
	end

	assign rep_done = (rep_reg >= `MIN_REPEAT);
	assign send_err = (err_in_reg || err_out_reg) && !lost_reg && (cls_next != cls_pwr)
		&& (cls_next != cls_selftst);

	// Boundary update: switch up at once (disruptive operation only from idle), down only after six repeats
	always_comb begin
		cls_next     = cls_reg;
		rep_next     = rep_reg;
		char_next    = char_reg;
		err_now_next = err_now_reg;
		st_rpt_next  = st_rpt_reg;
		st_pass_next = st_pass_reg;
		err_in_next  = err_in_reg;
		err_out_next = err_out_reg;
		if (tick) begin
			// Disruptive operation may only break into idle, never another message
			if ((cand > cls_reg && cand != cls_disrupt)
				|| (cand != cls_reg && (rep_done || cls_reg == cls_idle))) begin
				cls_next = cand;
				rep_next = 3'd1;
			end else if (!rep_done) begin
				rep_next = rep_reg + 3'd1;
			end
			err_now_next = send_err;
			if (send_err) begin
				char_next    = (err_in_reg && err_out_reg) ? `DN_ERR_BOTH
					: (err_in_reg ? `DN_ERR_IN : `DN_ERR_OUT);
				err_in_next  = 1'b0;
				err_out_next = 1'b0;
			end else begin
				char_next = class_code(cls_next, i_selftest_running,
					st_pass_reg, loop1_reg, loop2_reg);
			end
			// Pass or fail report retires after its six repeats
			if (cls_reg == cls_selftst && !i_selftest_running && rep_next >= `MIN_REPEAT) begin
				st_rpt_next = 1'b0;
			end
		end
		// Events landing on a clear are kept: sets come last
		if (i_selftest_done) begin
			st_rpt_next  = 1'b1;
			st_pass_next = i_selftest_pass;
			// Report is a new code, so its six repeats start afresh
			if (cls_next == cls_selftst) begin
				rep_next = 3'd0;
			end
		end
		if (i_blk_err_in && !lost_reg) begin
			err_in_next = 1'b1;
		end
		if (i_blk_err_out && !lost_reg) begin
			err_out_next = 1'b1;
		end
		// Reports pending at signal loss are dropped rather than sent late
		if (lost_reg) begin
			err_in_next  = 1'b0;
			err_out_next = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			cls_reg     <= cls_idle;
			rep_reg     <= 3'd0;
			char_reg    <= `DN_IDLE;
			err_now_reg <= 1'b0;
			st_rpt_reg  <= 1'b0;
			st_pass_reg <= 1'b0;
			err_in_reg  <= 1'b0;
			err_out_reg <= 1'b0;
		end else begin
			cls_reg     <= cls_next;
			rep_reg     <= rep_next;
			char_reg    <= char_next;
			err_now_reg <= err_now_next;
			st_rpt_reg  <= st_rpt_next;
			st_pass_reg <= st_pass_next;
			err_in_reg  <= err_in_next;
			err_out_reg <= err_out_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_mf_tick       = tick;
	assign o_sc1_char      = char_reg;
	assign o_rsvd_sc_chars = `RSVD_SC_FILL;
	assign o_loop_first    = loop1_reg;
	assign o_loop_second   = loop2_reg;
	assign o_selftest_req  = st_req_reg;
	assign o_te_power_loss = te_pl_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!rst_n);

	a_pwr_loss_first: assert property (
		tick && pwr_reg |=> o_sc1_char == `DN_PWR_LOSS && cls_reg == cls_pwr)
		else $error("power loss not sent at boundary");

	a_selftest_preempt: assert property (
		tick && !pwr_reg && cls_reg != cls_pwr && i_selftest_running
		|=> o_sc1_char == `DN_ST_RUN)
		else $error("self-test running not sent");

	a_min_repeat: assert property (
		tick && cls_reg != cls_idle && !rep_done && cand <= cls_reg && !i_selftest_done
		|=> cls_reg == $past(cls_reg) && rep_reg == $past(rep_reg) + 3'd1)
		else $error("message left before six repeats");

	a_err_once: assert property (
		tick && send_err && !(i_blk_err_in || i_blk_err_out)
		|=> !err_in_reg && !err_out_reg)
		else $error("error report pending after it was sent");

	a_err_not_over_st: assert property (
		err_now_reg |-> cls_reg != cls_pwr && cls_reg != cls_selftst)
		else $error("error report replaced power loss or self-test");

	a_no_err_lost: assert property (
		lost_reg && !err_in_reg && !err_out_reg |=> !err_in_reg && !err_out_reg)
		else $error("error report armed while network signal lost");

	a_rx_loss_code: assert property (
		cls_reg == cls_rx_loss && !err_now_reg |-> o_sc1_char == `DN_RX_LOSS)
		else $error("signal loss code wrong");

	a_idle_code: assert property (
		cls_reg == cls_idle && !err_now_reg |-> o_sc1_char == `DN_IDLE)
		else $error("idle code wrong");

	a_loop_both: assert property (
		acc && acc_code == `UP_LOOP12 |=> o_loop_first && o_loop_second)
		else $error("both-bearer loop not set");

	a_loop_release: assert property (
		acc && acc_code == `UP_IDLE |=> !o_loop_first && !o_loop_second)
		else $error("loop not released by idle");

	c_loop_set:   cover property (acc && acc_code == `UP_LOOP1 ##1 o_loop_first);
	c_err_sent:   cover property (tick && send_err);
	c_st_report:  cover property (i_selftest_done ##[1:1000] tick ##1 cls_reg == cls_selftst);
	c_pwr_switch: cover property (cls_reg == cls_rx_loss ##1 cls_reg == cls_pwr);

endmodule

// ==== verilog/nt_maint_defs.svh ====
// Constants for the layer 1 maintenance messaging block
`ifndef NT_MAINT_DEFS_SVH
`define NT_MAINT_DEFS_SVH

// ----------------------------------------------------------------
// Downstream character codes (first bit sent is the MSB)
// ----------------------------------------------------------------
`define DN_IDLE       4'h0
`define DN_PWR_LOSS   4'hf
`define DN_ST_PASS    4'h2
`define DN_ST_FAIL    4'h1
`define DN_ST_RUN     4'h7
`define DN_ERR_BOTH   4'hc
`define DN_ERR_IN     4'h8
`define DN_ERR_OUT    4'h4
`define DN_RX_LOSS    4'ha
`define DN_DISRUPT    4'h3
`define DN_MODEM      4'h6

// ----------------------------------------------------------------
// Upstream character codes
// ----------------------------------------------------------------
`define UP_IDLE       4'hf
`define UP_PWR_LOSS   4'h0
`define UP_ST_REQ     4'h1
`define UP_LOOP1      4'h7
`define UP_LOOP2      4'hb
`define UP_LOOP12     4'h3
`define UP_MODEM_A    4'hd
`define UP_MODEM_B    4'hc

// ----------------------------------------------------------------
// Repetition, acceptance and timing
// ----------------------------------------------------------------
`define MIN_REPEAT    3'd6
`define ACCEPT_COUNT  2'd3
`define RSVD_SC_FILL  16'h0000
`define MF_PERIOD_NS  5000000
`define CLK_PERIOD_NS 4
`define MF_CYCLES     (`MF_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ==== verilog/nt_maint_pkg.sv ====
// Types and shared functions of the maintenance messaging block
`include "nt_maint_defs.svh"

package nt_maint_pkg;

	// Downstream message classes, numbered in rising priority
	typedef enum logic [2:0] {
		cls_idle    = 3'h0,
		cls_modem   = 3'h1,
		cls_disrupt = 3'h2,
		cls_rx_loss = 3'h3,
		cls_loop    = 3'h4,
		cls_selftst = 3'h5,
		cls_pwr     = 3'h6
	} msg_class_t;

	// Upstream code is assigned or reserved
	function automatic logic up_code_valid(input logic [3:0] code);
		case (code)
			`UP_IDLE, `UP_PWR_LOSS, `UP_ST_REQ, `UP_LOOP1, `UP_LOOP2,
			`UP_LOOP12, `UP_MODEM_A, `UP_MODEM_B: up_code_valid = 1'b1;
			default: up_code_valid = 1'b0;
		endcase
	endfunction

endpackage

// ==== verilog/nt_mf_timer.sv ====
// Multiframe divider: one-cycle enable per multiframe period
`timescale 1ns/1ps
`include "nt_maint_defs.svh"

module nt_mf_timer import nt_maint_pkg::*; #(
	parameter int CYCLES = `MF_CYCLES
) (
	// Clock and synchronised reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Multiframe boundary enable
	output logic      o_tick
);

	localparam int W = (CYCLES > 2) ? $clog2(CYCLES) : 1;
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	// Wrap at the period end
	always_comb begin
		if (cnt_reg == LAST) begin
			cnt_next = '0;
		end else begin
			cnt_next = cnt_reg + W'(1);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign o_tick = (cnt_reg == LAST);

endmodule

// ==== verilog/nt_maint_rx.sv ====
// Upstream character acceptance after consecutive identical codes
`timescale 1ns/1ps
`include "nt_maint_defs.svh"

module nt_maint_rx import nt_maint_pkg::*; (
	// Clock and synchronised reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// Received upstream character, one per multiframe
	input  wire logic       i_strobe,
	input  wire logic [3:0] i_char,
	// Accepted message, pulse per character once accepted
	output logic            o_acc,
	output logic [3:0]      o_acc_code
);

	logic [3:0] last_reg, last_next;
	logic [1:0] run_reg, run_next;
	logic       acc_reg, acc_next;

	// Count repeats of the same valid code, saturating at acceptance
	always_comb begin
		last_next = last_reg;
		run_next  = run_reg;
		acc_next  = 1'b0;
		if (i_strobe) begin
			last_next = i_char;
			if (!up_code_valid(i_char)) begin
				run_next = 2'd0;
			end else if (i_char == last_reg && run_reg != 2'd0) begin
				run_next = (run_reg == `ACCEPT_COUNT) ? run_reg : run_reg + 2'd1;
			end else begin
				run_next = 2'd1;
			end
			acc_next = (run_next == `ACCEPT_COUNT);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			last_reg <= `UP_IDLE;
			run_reg  <= 2'd0;
			acc_reg  <= 1'b0;
		end else begin
			last_reg <= last_next;
			run_reg  <= run_next;
			acc_reg  <= acc_next;
		end
	end

	assign o_acc      = acc_reg;
	assign o_acc_code = last_reg;

	a_accept_three: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_acc |-> $past(run_reg) >= 2'd2 && $past(last_reg) == last_reg)
		else $error("accepted before three identical characters");

endmodule

// ==== test/te_model.sv ====
// Terminal-side model sending one upstream character per multiframe
`timescale 1ns/1ps

module te_model (
	// Clock and multiframe boundary
	input  wire logic       i_clk,
	input  wire logic       i_tick,
	// Code the terminal keeps sending
	input  wire logic [3:0] i_code,
	// Upstream character towards the block
	output logic            o_strobe,
	output logic [3:0]      o_char
);
	// --------------------------------
	// Character launch
	// --------------------------------
	initial begin
		o_strobe = 1'b0;
		o_char   = 4'h0;
	end

	// Held for one sampled edge, then the line shows the inverse, not stale data
	always @(posedge i_clk) begin
		if (i_tick === 1'b1) begin
			#1 o_strobe = 1'b1;
			o_char = i_code;
			@(posedge i_clk);
			#1 o_strobe = 1'b0;
			o_char = ~o_char;
		end
	end
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the maintenance messaging block
`timescale 1ns/1ps
`include "nt_maint_defs.svh"

module tb_top;
	localparam int         MF    = 20;
	localparam int         LIMIT = 20000;
	localparam logic [3:0] IND1  = 4'hd;

	logic        clk, arst_n, pwr_fail, sig_lost, err_in, err_out;
	logic        st_run, st_done, st_pass, disrupt, modem, up_strobe;
	logic [3:0]  te_code, up_char, dn_char, dn_char_m;
	logic [15:0] rsvd;
	logic        tick, loop1, loop2, st_req, te_pwr;
	int          error_cnt, compares, cycles, st_req_cnt;

	// --------------------------------
	// Design and terminal model
	// --------------------------------
	nt_maint_msg #(.MF_CYCLES(MF), .LOOP1_IND_CODE(IND1)) dut (
		.i_mclk(clk), .i_arst_n(arst_n), .i_up_strobe(up_strobe), .i_up_char(up_char),
		.i_pwr_fail(pwr_fail), .i_net_sig_lost(sig_lost), .i_blk_err_in(err_in),
		.i_blk_err_out(err_out), .i_selftest_running(st_run), .i_selftest_done(st_done),
		.i_selftest_pass(st_pass), .i_disruptive_op(disrupt), .i_modem_master(modem),
		.o_mf_tick(tick), .o_sc1_char(dn_char), .o_rsvd_sc_chars(rsvd),
		.o_loop_first(loop1), .o_loop_second(loop2), .o_selftest_req(st_req),
		.o_te_power_loss(te_pwr));

	// Second copy in the modem role, looked at only where that role matters
	nt_maint_msg #(.MF_CYCLES(MF), .MODEM_ROLE(1'b1), .LOOP1_IND_CODE(IND1)) dut_modem (
		.i_mclk(clk), .i_arst_n(arst_n), .i_up_strobe(up_strobe), .i_up_char(up_char),
		.i_pwr_fail(pwr_fail), .i_net_sig_lost(sig_lost), .i_blk_err_in(err_in),
		.i_blk_err_out(err_out), .i_selftest_running(st_run), .i_selftest_done(st_done),
		.i_selftest_pass(st_pass), .i_disruptive_op(disrupt), .i_modem_master(modem),
		.o_mf_tick(), .o_sc1_char(dn_char_m), .o_rsvd_sc_chars(),
		.o_loop_first(), .o_loop_second(), .o_selftest_req(),
		.o_te_power_loss());

	te_model te (.i_clk(clk), .i_tick(tick), .i_code(te_code), .o_strobe(up_strobe),
		.o_char(up_char));

	// Clock, pulse counter and hang guard
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (st_req === 1'b1)
			st_req_cnt++;
		if (cycles == LIMIT) begin
			error_cnt++;
			$display("CHECK FAILED run length expected below %0d seen %0d", LIMIT, cycles);
			end_of_test();
		end
	end

	// --------------------------------
	// Shared tasks
	// --------------------------------
	task automatic chk_char(input string name, input logic [3:0] exp, input logic [3:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, got);
		end
	endtask

	// Character loaded at the next boundary, read once it has settled
	task automatic next_char(output logic [3:0] c);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (tick !== 1'b1 && n < 2 * MF);
		chk_bit("boundary seen", 1'b1, n < 2 * MF);
		@(posedge clk);
		#1 c = dn_char;
	endtask

	task automatic exp_chars(input string name, input logic [3:0] code, input int n);
		logic [3:0] c;
		repeat (n) begin
			next_char(c);
			chk_char(name, code, c);
		end
	endtask

	// Bounded wait where several class changes may queue up
	task automatic wait_char(input string name, input logic [3:0] code, input int lim);
		logic [3:0] c;
		int i;
		i = 0;
		do begin
			next_char(c);
			i++;
		end while (c !== code && i < lim);
		chk_char(name, code, c);
	endtask

	// Terminal sends a code for n frames; acceptance lands two edges later
	task automatic send(input logic [3:0] code, input int n);
		logic [3:0] c;
		te_code = code;
		repeat (n) next_char(c);
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic err_pulse(input logic in_dir, input logic out_dir);
		err_in = in_dir;
		err_out = out_dir;
		@(posedge clk);
		#1 err_in = 1'b0;
		err_out = 1'b0;
	endtask

	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic t_idle;
		modem = 1'b1;
		exp_chars("idle", `DN_IDLE, 3);
		chk_char("modem role", `DN_MODEM, dn_char_m);
		modem = 1'b0;
		chk_bit("reserved zero", 1'b1, rsvd === `RSVD_SC_FILL);
	endtask

	task automatic t_repeat;
		disrupt = 1'b1;
		exp_chars("disrupt", `DN_DISRUPT, 1);
		chk_char("modem kept", `DN_MODEM, dn_char_m);
		disrupt = 1'b0;
		exp_chars("disrupt held", `DN_DISRUPT, 5);
		exp_chars("idle after", `DN_IDLE, 1);
	endtask

	task automatic t_priority;
		disrupt = 1'b1;
		exp_chars("disrupt", `DN_DISRUPT, 1);
		sig_lost = 1'b1;
		exp_chars("rx loss", `DN_RX_LOSS, 1);
		te_code = `UP_LOOP1;
		wait_char("loop ind", IND1, 6);
		chk_bit("loop first", 1'b1, loop1);
		st_run = 1'b1;
		exp_chars("self test", `DN_ST_RUN, 1);
		pwr_fail = 1'b1;
		exp_chars("power loss", `DN_PWR_LOSS, 1);
		pwr_fail = 1'b0;
		st_run = 1'b0;
		sig_lost = 1'b0;
		disrupt = 1'b0;
		te_code = `UP_IDLE;
		wait_char("idle again", `DN_IDLE, 40);
		chk_bit("loop released", 1'b0, loop1);
	endtask

	task automatic t_upstream;
		send(`UP_LOOP1, 2);
		send(4'h5, 1);
		send(`UP_LOOP1, 2);
		chk_bit("broken run", 1'b0, loop1);
		send(`UP_LOOP1, 1);
		chk_bit("loop1 only", 1'b1, loop1 & ~loop2);
		send(`UP_LOOP12, 3);
		chk_bit("both loops", 1'b1, loop1 & loop2);
		send(`UP_LOOP2, 3);
		chk_bit("loop2 only", 1'b1, ~loop1 & loop2);
		send(`UP_PWR_LOSS, 3);
		chk_bit("te power loss", 1'b1, te_pwr & ~loop2);
		st_req_cnt = 0;
		send(`UP_ST_REQ, 5);
		chk_bit("one test request", 1'b1, st_req_cnt == 1);
		send(`UP_IDLE, 3);
		chk_bit("power loss gone", 1'b0, te_pwr);
	endtask

	task automatic t_errors;
		logic [1:0] ev [3];
		logic [3:0] ec [3];
		ev = '{2'b10, 2'b01, 2'b11};
		ec = '{`DN_ERR_IN, `DN_ERR_OUT, `DN_ERR_BOTH};
		for (int i = 0; i < 3; i++) begin
			err_pulse(ev[i][1], ev[i][0]);
			exp_chars("error report", ec[i], 1);
			exp_chars("after report", `DN_IDLE, 1);
		end
		sig_lost = 1'b1;
		exp_chars("rx loss", `DN_RX_LOSS, 1);
		err_pulse(1'b1, 1'b1);
		exp_chars("no report", `DN_RX_LOSS, 2);
		sig_lost = 1'b0;
		wait_char("idle again", `DN_IDLE, 10);
	endtask

	task automatic t_selftest;
		logic [3:0] rep [2];
		rep = '{`DN_ST_FAIL, `DN_ST_PASS};
		for (int p = 0; p < 2; p++) begin
			st_run = 1'b1;
			exp_chars("running", `DN_ST_RUN, 6);
			st_run = 1'b0;
			st_done = 1'b1;
			st_pass = p[0];
			@(posedge clk);
			#1 st_done = 1'b0;
			exp_chars("report", rep[p], 6);
			exp_chars("idle after", `DN_IDLE, 1);
		end
	endtask

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		{clk, arst_n, pwr_fail, sig_lost, err_in, err_out} = '0;
		{st_run, st_done, st_pass, disrupt, modem} = '0;
		te_code = `UP_IDLE;
		{error_cnt, compares, cycles, st_req_cnt} = '0;
		repeat (5) @(posedge clk);
		#1 arst_n = 1'b1;
		t_idle();
		t_repeat();
		t_priority();
		t_upstream();
		t_errors();
		t_selftest();
		end_of_test();
	end
endmodule
